//--- verilog/arbsq_params.svh
// Constants for the waveform sequencer command back end
`ifndef ARBSQ_PARAMS_SVH
`define ARBSQ_PARAMS_SVH

`define ARBSQ_NODES         7'h64
`define ARBSQ_NODE_MAX      16'h0063
`define ARBSQ_FIRST_NODE    7'h01
`define ARBSQ_F4_MAX        16'h270f
`define ARBSQ_I4_MAX        16'h270f
`define ARBSQ_CFG_MAX       16'h0003
`define ARBSQ_FLAG_MAX      16'h0001
`define ARBSQ_CFG_REPEAT    0
`define ARBSQ_CFG_FROM_STP  1
`define ARBSQ_CLK_PERIOD_NS 25
`define ARBSQ_TIME_UNIT_NS  1000000
`define ARBSQ_TICK_CYCLES   (`ARBSQ_TIME_UNIT_NS / `ARBSQ_CLK_PERIOD_NS)

`endif

//--- verilog/arbsq_pkg.sv
// Types for the waveform sequencer command back end
package arbsq_pkg;

  typedef enum logic [4:0] {
    ARBSQ_SEL_NODE    = 5'h00,
    ARBSQ_NODE_VOLT   = 5'h01,
    ARBSQ_NODE_TIME   = 5'h02,
    ARBSQ_START_POINT = 5'h03,
    ARBSQ_CONFIG      = 5'h04,
    ARBSQ_TRIGGER     = 5'h05,
    ARBSQ_WAVE_OFF    = 5'h06,
    ARBSQ_OUTPUT      = 5'h07,
    ARBSQ_LOCKOUT     = 5'h08,
    ARBSQ_REG_MODE    = 5'h09,
    ARBSQ_RANGE       = 5'h0a,
    ARBSQ_REQUEST_MODE_CMD        = 5'h0b,
    ARBSQ_VOLTAGE_SETPOINT_CMD        = 5'h0c,
    ARBSQ_CURRENT_SETPOINT_CMD        = 5'h0d,
    ARBSQ_Q_NODE      = 5'h10,
    ARBSQ_Q_NODE_VOLT = 5'h11,
    ARBSQ_Q_NODE_TIME = 5'h12,
    ARBSQ_Q_START     = 5'h13,
    ARBSQ_Q_CONFIG    = 5'h14,
    ARBSQ_Q_VOLTAGE_SETPOINT_CMD      = 5'h15,
    ARBSQ_Q_CURRENT_SETPOINT_CMD      = 5'h16,
    ARBSQ_Q_VMEAS     = 5'h17,
    ARBSQ_Q_IMEAS     = 5'h18,
    ARBSQ_Q_REQUEST_MODE_CMD      = 5'h19,
    ARBSQ_Q_SRQ       = 5'h1a,
    ARBSQ_Q_COND      = 5'h1b
  } arbsq_cmd_t;

  typedef enum logic [1:0] {
    ARBSQ_IDLE  = 2'b01,
    ARBSQ_DWELL = 2'b10
  } arbsq_state_t;

endpackage

//--- verilog/arbsq_core.sv
// Command back end and waveform sequencer of a programmable supply
`timescale 1ns/100ps
`include "arbsq_params.svh"

module arbsq_core
  import arbsq_pkg::*;
#(
  parameter int TICK_CYCLES = `ARBSQ_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Parsed commands
  input  wire logic        cmd_valid,
  input  wire arbsq_cmd_t  cmd_code,
  input  wire logic [15:0] cmd_arg,
  // Query answers
  output logic             rsp_valid,
  output logic      [15:0] rsp_data,
  // Status pins from the power stage and front panel
  input  wire logic        cc_pin,
  input  wire logic        voltage_regulating_flag,
  input  wire logic        overload_pin,
  input  wire logic        error_pin,
  input  wire logic        overtemp_pin,
  input  wire logic        curr_ovf_pin,
  input  wire logic        volt_ovf_pin,
  input  wire logic        runtime_abort_pin,
  input  wire logic        repeat_abort_pin,
  input  wire logic        meter_range_flag,
  input  wire logic        peak_mode_flag,
  input  wire logic        panel_range_pin,
  input  wire logic        panel_mode_pin,
  input  wire logic        panel_prog_pin,
  input  wire logic        bus_lockout_pin,
  // Meter readings, same clock
  input  wire logic [15:0] meas_volt,
  input  wire logic [15:0] meas_curr,
  // Control outputs
  output logic             output_on,
  output logic             range_sel,
  output logic             mode_sel,
  output logic             lockout,
  output logic      [15:0] volt_setpoint,
  output logic      [15:0] curr_setpoint,
  output logic             prog_exit,
  output logic             srq_pending,
  output logic      [15:0] device_condition,
  // Sequencer outputs
  output logic             seq_active,
  output logic       [6:0] seq_node,
  output logic      [15:0] seq_volt
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // Node storage, no reset: contents are undefined until written
  logic [15:0] volt_mem [0:`ARBSQ_NODES-1];
  logic [15:0] time_mem [0:`ARBSQ_NODES-1];

  logic [14:0] pin_meta_reg, pin_sync_reg;
  logic        cc_s, cv_s, ovl_s, err_s, ovt_s, ovli_s, ovlv_s, ati_s, aco_s;
  logic        ir_s, pk_s, prng_s, pmode_s, pprog_s, bllo_s;
  assign {cc_s, cv_s, ovl_s, err_s, ovt_s, ovli_s, ovlv_s, ati_s, aco_s,
          ir_s, pk_s, prng_s, pmode_s, pprog_s, bllo_s} = pin_sync_reg;

  // Control state
  logic [6:0]  node_sel_reg, node_sel_next, start_pt_reg, start_pt_next;
  logic [1:0]  cfg_reg, cfg_next;
  logic        on_reg, on_next, llo_reg, llo_next, rng_reg, rng_next;
  logic        mode_reg, mode_next, request_mode_cmd_reg, request_mode_cmd_next, srq_reg, srq_next;
  logic        cc_prev_reg, lock_reg, lock_next, pexit_reg, pexit_next;
  logic [15:0] voltage_setpoint_cmd_reg, voltage_setpoint_cmd_next, current_setpoint_cmd_reg, current_setpoint_cmd_next, dc_reg, dc_next;
  logic        rsp_valid_reg, rsp_valid_next, srqo_reg, srqo_next;
  logic [15:0] rsp_data_reg, rsp_data_next;
  logic        volt_we, time_we, seq_start, seq_stop, lock_eff, srq_clr;

  // Sequencer state
  arbsq_state_t state_reg, state_next;
  logic [6:0]   node_reg, node_next, load_node;
  logic [TICK_W-1:0] tick_reg, tick_next;
  logic [15:0]  dwell_reg, dwell_next, svolt_reg, svolt_next;
  logic         load_en;

  function automatic logic is_end(input logic [6:0] n);
    is_end = (n >= `ARBSQ_NODES) || (time_mem[n] == 16'h0000);
  endfunction

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lim);
    in_range = (v <= lim);
  endfunction

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_meta_reg <= 15'h0000;
      pin_sync_reg <= 15'h0000;
    end else if (clk_en) begin
      pin_meta_reg <= {cc_pin, voltage_regulating_flag, overload_pin, error_pin,
                       overtemp_pin, curr_ovf_pin, volt_ovf_pin, runtime_abort_pin,
                       repeat_abort_pin, meter_range_flag, peak_mode_flag,
                       panel_range_pin, panel_mode_pin, panel_prog_pin,
                       bus_lockout_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_comb begin
    node_sel_next  = node_sel_reg;
    start_pt_next  = start_pt_reg;
    cfg_next       = cfg_reg;
    on_next        = on_reg;
    llo_next       = llo_reg;
    rng_next       = rng_reg;
    mode_next      = mode_reg;
    request_mode_cmd_next      = request_mode_cmd_reg;
    voltage_setpoint_cmd_next      = voltage_setpoint_cmd_reg;
    current_setpoint_cmd_next      = current_setpoint_cmd_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next  = rsp_data_reg;
    pexit_next     = 1'b0;
    volt_we        = 1'b0;
    time_we        = 1'b0;
    seq_start      = 1'b0;
    seq_stop       = 1'b0;
    srq_clr        = 1'b0;
    lock_eff       = llo_reg | bllo_s;
    if (cmd_valid) begin
      case (cmd_code)
        ARBSQ_SEL_NODE:    if (in_range(cmd_arg, `ARBSQ_NODE_MAX)) node_sel_next = cmd_arg[6:0];
        ARBSQ_NODE_VOLT:   volt_we = in_range(cmd_arg, `ARBSQ_F4_MAX);
        ARBSQ_NODE_TIME:   time_we = in_range(cmd_arg, `ARBSQ_I4_MAX);
        ARBSQ_START_POINT: if (in_range(cmd_arg, `ARBSQ_NODE_MAX)) start_pt_next = cmd_arg[6:0];
        ARBSQ_CONFIG:      if (in_range(cmd_arg, `ARBSQ_CFG_MAX)) cfg_next = cmd_arg[1:0];
        ARBSQ_TRIGGER:     seq_start = on_reg;
        ARBSQ_WAVE_OFF: begin
          if (cmd_arg == 16'h0000) begin
            seq_stop   = 1'b1;
            pexit_next = pprog_s;
          end
        end
        ARBSQ_OUTPUT:      if (in_range(cmd_arg, `ARBSQ_FLAG_MAX)) on_next = cmd_arg[0];
        ARBSQ_LOCKOUT:     if (in_range(cmd_arg, `ARBSQ_FLAG_MAX)) llo_next = cmd_arg[0];
        // Refused while manual operation is still live
        ARBSQ_REG_MODE:    if (lock_eff && in_range(cmd_arg, `ARBSQ_FLAG_MAX)) mode_next = cmd_arg[0];
        ARBSQ_RANGE:       if (lock_eff && in_range(cmd_arg, `ARBSQ_FLAG_MAX)) rng_next = cmd_arg[0];
        ARBSQ_REQUEST_MODE_CMD:        if (in_range(cmd_arg, `ARBSQ_FLAG_MAX)) request_mode_cmd_next = cmd_arg[0];
        ARBSQ_VOLTAGE_SETPOINT_CMD:        voltage_setpoint_cmd_next = cmd_arg;
        ARBSQ_CURRENT_SETPOINT_CMD:        current_setpoint_cmd_next = cmd_arg;
        ARBSQ_Q_NODE:      begin rsp_valid_next = 1'b1; rsp_data_next = {9'h000, node_sel_reg}; end
        ARBSQ_Q_NODE_VOLT: begin rsp_valid_next = 1'b1; rsp_data_next = volt_mem[node_sel_reg]; end
        ARBSQ_Q_NODE_TIME: begin rsp_valid_next = 1'b1; rsp_data_next = time_mem[node_sel_reg]; end
        ARBSQ_Q_START:     begin rsp_valid_next = 1'b1; rsp_data_next = {9'h000, start_pt_reg}; end
        ARBSQ_Q_CONFIG:    begin rsp_valid_next = 1'b1; rsp_data_next = {14'h0000, cfg_reg}; end
        ARBSQ_Q_VOLTAGE_SETPOINT_CMD:      begin rsp_valid_next = 1'b1; rsp_data_next = voltage_setpoint_cmd_reg; end
        ARBSQ_Q_CURRENT_SETPOINT_CMD:      begin rsp_valid_next = 1'b1; rsp_data_next = current_setpoint_cmd_reg; end
        ARBSQ_Q_VMEAS:     begin rsp_valid_next = 1'b1; rsp_data_next = meas_volt; end
        ARBSQ_Q_IMEAS:     begin rsp_valid_next = 1'b1; rsp_data_next = meas_curr; end
        ARBSQ_Q_REQUEST_MODE_CMD:      begin rsp_valid_next = 1'b1; rsp_data_next = {15'h0000, request_mode_cmd_reg}; end
        ARBSQ_Q_SRQ: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = {15'h0000, srq_reg};
          srq_clr        = 1'b1;
        end
        ARBSQ_Q_COND:      begin rsp_valid_next = 1'b1; rsp_data_next = dc_reg; end
        default:           rsp_valid_next = 1'b0;
      endcase
    end
    lock_next = llo_next | bllo_s;
    // Panel positions are tracked while local, so lockout starts from them
    if (!lock_next) begin
      rng_next  = prng_s;
      mode_next = pmode_s;
    end
    seq_stop = seq_stop | (on_reg & ~on_next);
    // A new event in the read cycle survives the clear
    srq_next = (srq_reg & ~srq_clr) | (cc_s & ~cc_prev_reg) | (on_reg & ~on_next);
    srqo_next = srq_next & request_mode_cmd_next;
    dc_next  = {on_reg, (state_reg == ARBSQ_DWELL) | pprog_s, mode_reg, rng_reg,
                cc_s, cv_s, ovl_s, err_s, ovt_s, lock_reg, ovli_s, ovlv_s,
                ati_s, aco_s, ir_s, pk_s};
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      node_sel_reg  <= 7'h00;
      start_pt_reg  <= 7'h00;
      cfg_reg       <= 2'h0;
      on_reg        <= 1'b0;
      llo_reg       <= 1'b0;
      rng_reg       <= 1'b0;
      mode_reg      <= 1'b0;
      request_mode_cmd_reg      <= 1'b0;
      srq_reg       <= 1'b0;
      srqo_reg      <= 1'b0;
      cc_prev_reg   <= 1'b0;
      lock_reg      <= 1'b0;
      pexit_reg     <= 1'b0;
      voltage_setpoint_cmd_reg      <= 16'h0000;
      current_setpoint_cmd_reg      <= 16'h0000;
      dc_reg        <= 16'h0000;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= 16'h0000;
    end else if (clk_en) begin
      node_sel_reg  <= node_sel_next;
      start_pt_reg  <= start_pt_next;
      cfg_reg       <= cfg_next;
      on_reg        <= on_next;
      llo_reg       <= llo_next;
      rng_reg       <= rng_next;
      mode_reg      <= mode_next;
      request_mode_cmd_reg      <= request_mode_cmd_next;
      srq_reg       <= srq_next;
      srqo_reg      <= srqo_next;
      cc_prev_reg   <= cc_s;
      lock_reg      <= lock_next;
      pexit_reg     <= pexit_next;
      voltage_setpoint_cmd_reg      <= voltage_setpoint_cmd_next;
      current_setpoint_cmd_reg      <= current_setpoint_cmd_next;
      dc_reg        <= dc_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg  <= rsp_data_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en && volt_we) volt_mem[node_sel_reg] <= cmd_arg;
    if (clk_en && time_we) time_mem[node_sel_reg] <= cmd_arg;
  end

  always_comb begin
    state_next = state_reg;
    node_next  = node_reg;
    tick_next  = tick_reg;
    dwell_next = dwell_reg;
    svolt_next = svolt_reg;
    load_en    = 1'b0;
    load_node  = node_reg;
    case (state_reg)
      ARBSQ_IDLE: begin
        if (seq_start) begin
          load_node = cfg_reg[`ARBSQ_CFG_FROM_STP] ? start_pt_reg : `ARBSQ_FIRST_NODE;
          load_en   = ~is_end(load_node);
        end
      end
      ARBSQ_DWELL: begin
        if (seq_stop) begin
          state_next = ARBSQ_IDLE;
        end else if (tick_reg == TICK_W'(TICK_CYCLES - 1)) begin
          tick_next = '0;
          if (dwell_reg <= 16'h0001) begin
            load_node = node_reg + 7'h01;
            if (!is_end(load_node)) begin
              load_en = 1'b1;
            end else if (cfg_reg[`ARBSQ_CFG_REPEAT]) begin
              load_node = `ARBSQ_FIRST_NODE;
              load_en   = ~is_end(load_node);
            end
            if (!load_en) state_next = ARBSQ_IDLE;
          end else begin
            dwell_next = dwell_reg - 16'h0001;
          end
        end else begin
          tick_next = tick_reg + TICK_W'(1);
        end
      end
      default: state_next = ARBSQ_IDLE;
    endcase
    if (load_en) begin
      state_next = ARBSQ_DWELL;
      node_next  = load_node;
      tick_next  = '0;
      dwell_next = time_mem[load_node];
      svolt_next = volt_mem[load_node];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ARBSQ_IDLE;
      node_reg  <= 7'h00;
      tick_reg  <= '0;
      dwell_reg <= 16'h0000;
      svolt_reg <= 16'h0000;
    end else if (clk_en) begin
      state_reg <= state_next;
      node_reg  <= node_next;
      tick_reg  <= tick_next;
      dwell_reg <= dwell_next;
      svolt_reg <= svolt_next;
    end
  end

  assign rsp_valid        = rsp_valid_reg;
  assign rsp_data         = rsp_data_reg;
  assign output_on        = on_reg;
  assign range_sel        = rng_reg;
  assign mode_sel         = mode_reg;
  assign lockout          = lock_reg;
  assign volt_setpoint    = voltage_setpoint_cmd_reg;
  assign curr_setpoint    = current_setpoint_cmd_reg;
  assign prog_exit        = pexit_reg;
  assign srq_pending      = srqo_reg;
  assign device_condition = dc_reg;
  assign seq_active       = (state_reg == ARBSQ_DWELL);
  assign seq_node         = node_reg;
  assign seq_volt         = svolt_reg;

endmodule // arbsq_core

//--- test/arbsq_assertions.sv
// Port-level checks of the command back end
`timescale 1ns/100ps
module arbsq_checker
  import arbsq_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  // Commands and answers
  input wire logic        cmd_valid,
  input wire arbsq_cmd_t  cmd_code,
  input wire logic [15:0] cmd_arg,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  // Controls and status
  input wire logic        output_on,
  input wire logic        range_sel,
  input wire logic        mode_sel,
  input wire logic        lockout,
  input wire logic        prog_exit,
  input wire logic [15:0] device_condition,
  input wire logic        seq_active,
  input wire logic  [6:0] seq_node
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic take = clk_en && cmd_valid;
  wire logic stop = take && cmd_arg == 16'h0000;
  a_query_answered: assert property (take && cmd_code[4] |=> rsp_valid)
    else $error("query got no answer");
  a_write_silent: assert property (take && !cmd_code[4] |=> !rsp_valid)
    else $error("write produced an answer");
  a_cond_readback: assert property (take && cmd_code == ARBSQ_Q_COND
    |=> rsp_data == $past(device_condition)) else $error("condition answer differs");
  a_trigger_needs_on: assert property (take && cmd_code == ARBSQ_TRIGGER
    && !output_on && !seq_active |=> !seq_active) else $error("run began with output off");
  a_off_stops: assert property (stop && (cmd_code == ARBSQ_OUTPUT
    || cmd_code == ARBSQ_WAVE_OFF) |=> !seq_active) else $error("run did not stop");
  a_lock_sets: assert property (take && cmd_code == ARBSQ_LOCKOUT
    && cmd_arg == 16'h0001 |=> lockout) else $error("lockout not set");
  a_range_cmd: assert property (lockout && take && cmd_code == ARBSQ_RANGE
    && cmd_arg <= 16'h0001 |=> range_sel == $past(cmd_arg[0])) else $error("range wrong");
  a_mode_cmd: assert property (lockout && take && cmd_code == ARBSQ_REG_MODE
    && cmd_arg <= 16'h0001 |=> mode_sel == $past(cmd_arg[0])) else $error("mode wrong");
  a_cond_mirror: assert property ($past(clk_en) |->
    {device_condition[15], device_condition[6]} == $past({output_on, lockout}))
    else $error("condition bits lag wrongly");
  a_prog_exit_cause: assert property (prog_exit |->
    $past(stop && cmd_code == ARBSQ_WAVE_OFF)) else $error("stray programming exit");
  a_node_bound: assert property (seq_active |-> seq_node <= 7'h63)
    else $error("node index out of range");
endmodule // arbsq_checker

bind arbsq_core arbsq_checker chk_u (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .output_on(output_on), .range_sel(range_sel), .mode_sel(mode_sel),
  .lockout(lockout), .prog_exit(prog_exit), .device_condition(device_condition),
  .seq_active(seq_active), .seq_node(seq_node));

//--- test/arbsq_ctl_model.sv
// Remote controller model issuing parsed commands
`timescale 1ns/100ps
module arbsq_ctl_model
  import arbsq_pkg::*;
(
  // Clock
  input wire logic        sys_clk,
  // Command side
  output logic            cmd_valid,
  output arbsq_cmd_t      cmd_code,
  output logic     [15:0] cmd_arg,
  // Answer side
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = ARBSQ_Q_COND;
    cmd_arg = 16'h0000;
  end
  // One command per call; node writes follow a select issued earlier
  task automatic send(input arbsq_cmd_t c, input logic [15:0] a);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg <= a;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    // Idle argument inverted so a stale value never looks valid
    cmd_arg <= ~a;
    #1;
  endtask
  task automatic ask(input arbsq_cmd_t c, output logic ok, output logic [15:0] d);
    send(c, 16'h0000);
    ok = rsp_valid;
    d = rsp_data;
  endtask
endmodule // arbsq_ctl_model

//--- test/testbench.sv
// Self-checking bench for the command back end
`timescale 1ns/100ps
module testbench
  import arbsq_pkg::*;
;
  typedef struct packed {arbsq_cmd_t w; logic [15:0] a; arbsq_cmd_t r; logic [15:0] e;} arbsq_row_t;
  typedef struct packed {logic [1:0] c; logic [6:0] f; logic [7:0] n1; logic [7:0] n2;} arbsq_run_t;
  logic        sys_clk, reset, clk_en, cmd_valid, rsp_valid, output_on, range_sel, mode_sel;
  logic        lockout, prog_exit, srq_pending, seq_active, ok;
  logic [14:0] pins;
  logic [15:0] cmd_arg, rsp_data, meas_volt, meas_curr, vsp, isp, cond, seq_volt, d;
  logic  [6:0] seq_node;
  arbsq_cmd_t  cmd_code;
  int          err_total, n_tests, n;
  arbsq_row_t  rows [11] = '{'{ARBSQ_SEL_NODE, 16'h0005, ARBSQ_Q_NODE, 16'h0005},
    '{ARBSQ_SEL_NODE, 16'h0064, ARBSQ_Q_NODE, 16'h0005},
    '{ARBSQ_NODE_VOLT, 16'h270f, ARBSQ_Q_NODE_VOLT, 16'h270f},
    '{ARBSQ_NODE_VOLT, 16'h2710, ARBSQ_Q_NODE_VOLT, 16'h270f},
    '{ARBSQ_NODE_TIME, 16'h270f, ARBSQ_Q_NODE_TIME, 16'h270f},
    '{ARBSQ_START_POINT, 16'h0063, ARBSQ_Q_START, 16'h0063},
    '{ARBSQ_CONFIG, 16'h0003, ARBSQ_Q_CONFIG, 16'h0003},
    '{ARBSQ_CONFIG, 16'h0004, ARBSQ_Q_CONFIG, 16'h0003},
    '{ARBSQ_VOLTAGE_SETPOINT_CMD, 16'h1234, ARBSQ_Q_VOLTAGE_SETPOINT_CMD, 16'h1234},
    '{ARBSQ_CURRENT_SETPOINT_CMD, 16'h0456, ARBSQ_Q_CURRENT_SETPOINT_CMD, 16'h0456},
    '{ARBSQ_REQUEST_MODE_CMD, 16'h0001, ARBSQ_Q_REQUEST_MODE_CMD, 16'h0001}};
  arbsq_run_t  runs [4] = '{'{2'h0, 7'h01, 8'h82, 8'h00}, '{2'h1, 7'h01, 8'h82, 8'h81},
    '{2'h2, 7'h02, 8'h00, 8'h00}, '{2'h3, 7'h02, 8'h81, 8'h82}};
  always #12.5 sys_clk = ~sys_clk;
  arbsq_ctl_model ctl_u (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_arg(cmd_arg), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  arbsq_core #(.TICK_CYCLES(4)) dut_u (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .cc_pin(pins[14]), .voltage_regulating_flag(pins[13]),
    .overload_pin(pins[12]), .error_pin(pins[11]), .overtemp_pin(pins[10]),
    .curr_ovf_pin(pins[9]), .volt_ovf_pin(pins[8]), .runtime_abort_pin(pins[7]),
    .repeat_abort_pin(pins[6]), .meter_range_flag(pins[5]), .peak_mode_flag(pins[4]),
    .panel_range_pin(pins[3]), .panel_mode_pin(pins[2]), .panel_prog_pin(pins[1]),
    .bus_lockout_pin(pins[0]), .meas_volt(meas_volt), .meas_curr(meas_curr),
    .output_on(output_on), .range_sel(range_sel), .mode_sel(mode_sel), .lockout(lockout),
    .volt_setpoint(vsp), .curr_setpoint(isp), .prog_exit(prog_exit),
    .srq_pending(srq_pending), .device_condition(cond), .seq_active(seq_active),
    .seq_node(seq_node), .seq_volt(seq_volt));
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic q(input arbsq_cmd_t c, input logic [15:0] e);
    ctl_u.ask(c, ok, d);
    chk({15'h0000, ok}, 16'h0001, "no answer");
    chk(d, e, "answer data");
  endtask
  // Bounded wait for the sequencer to move; a stuck run ends the test
  task automatic step();
    logic [7:0] was;
    was = {seq_active, seq_node};
    n = 0;
    while ({seq_active, seq_node} === was) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 40) begin
        err_total++;
        $display("wrong value at %0t: sequencer stuck", $time);
        tally_and_finish();
      end
    end
  endtask
  function automatic logic [15:0] pos();
    return {8'h00, seq_active, seq_node & {7{seq_active}}};
  endfunction
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    pins = 15'h3554;
    meas_volt = 16'h0987;
    meas_curr = 16'h0321;
    err_total = 0;
    n_tests = 0;
    repeat (10) @(posedge sys_clk);
    chk({13'h0000, output_on, seq_active, rsp_valid}, 16'h0000, "reset outputs");
    chk(cond, 16'h0000, "reset condition");
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    foreach (rows[i]) begin
      ctl_u.send(rows[i].w, rows[i].a);
      q(rows[i].r, rows[i].e);
    end
    q(ARBSQ_Q_VMEAS, 16'h0987);
    q(ARBSQ_Q_IMEAS, 16'h0321);
    chk(vsp, 16'h1234, "voltage setpoint output");
    chk(isp, 16'h0456, "current setpoint output");
    ctl_u.send(ARBSQ_OUTPUT, 16'h0001);
    ctl_u.send(ARBSQ_LOCKOUT, 16'h0001);
    ctl_u.send(ARBSQ_RANGE, 16'h0001);
    chk({15'h0000, lockout}, 16'h0001, "lockout output");
    ctl_u.send(ARBSQ_REG_MODE, 16'h0000);
    chk({15'h0000, mode_sel}, 16'h0000, "mode output");
    repeat (3) @(posedge sys_clk);
    q(ARBSQ_Q_COND, 16'h96d5);
    ctl_u.send(ARBSQ_LOCKOUT, 16'h0000);
    repeat (3) @(posedge sys_clk);
    q(ARBSQ_Q_COND, 16'ha695);
    ctl_u.send(ARBSQ_RANGE, 16'h0001);
    chk({15'h0000, range_sel}, 16'h0000, "range while unlocked");
    pins[0] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ctl_u.send(ARBSQ_RANGE, 16'h0001);
    chk({15'h0000, range_sel}, 16'h0001, "range under bus lockout");
    pins[0] <= 1'b0;
    for (int k = 1; k < 4; k++) begin
      ctl_u.send(ARBSQ_SEL_NODE, 16'(k));
      ctl_u.send(ARBSQ_NODE_VOLT, 16'(k) << 8);
      ctl_u.send(ARBSQ_NODE_TIME, 16'(k < 3));
    end
    ctl_u.send(ARBSQ_START_POINT, 16'h0002);
    ctl_u.send(ARBSQ_OUTPUT, 16'h0000);
    ctl_u.send(ARBSQ_TRIGGER, 16'h0000);
    chk(pos(), 16'h0000, "run with output off");
    foreach (runs[i]) begin
      ctl_u.send(ARBSQ_CONFIG, {14'h0000, runs[i].c});
      ctl_u.send(ARBSQ_OUTPUT, 16'h0001);
      ctl_u.send(ARBSQ_TRIGGER, 16'h0000);
      chk(pos(), {8'h00, 1'b1, runs[i].f}, "first node");
      chk(seq_volt, {1'b0, runs[i].f, 8'h00}, "node voltage");
      step();
      chk({15'h0000, n inside {[4:5]}}, 16'h0001, "dwell length");
      chk(pos(), {8'h00, runs[i].n1}, "second step");
      if (runs[i].n1[7]) begin
        step();
        chk(pos(), {8'h00, runs[i].n2}, "third step");
      end
      ctl_u.send(ARBSQ_OUTPUT, 16'h0000);
      chk(pos(), 16'h0000, "stop by output off");
    end
    chk({15'h0000, srq_pending}, 16'h0001, "request pending");
    q(ARBSQ_Q_SRQ, 16'h0001);
    q(ARBSQ_Q_SRQ, 16'h0000);
    pins[1] <= 1'b1;
    ctl_u.send(ARBSQ_CONFIG, 16'h0001);
    ctl_u.send(ARBSQ_OUTPUT, 16'h0001);
    ctl_u.send(ARBSQ_TRIGGER, 16'h0000);
    ctl_u.send(ARBSQ_WAVE_OFF, 16'h0001);
    chk({15'h0000, seq_active}, 16'h0001, "nonzero wave off ignored");
    ctl_u.send(ARBSQ_WAVE_OFF, 16'h0000);
    chk({15'h0000, seq_active}, 16'h0000, "wave off stops");
    chk({15'h0000, prog_exit}, 16'h0001, "programming exit pulse");
    tally_and_finish();
  end
endmodule // testbench
